// ### design/bsk_map.svh
// Constants for the bit-test-skip and call execution block.
// Assumes a 14-bit instruction word and a 13-bit program counter.
`ifndef BSK_MAP_SVH
`define BSK_MAP_SVH

// Opcode field of the bit-test-skip-if-set instruction
`define BSK_SKIP_OPC_HI  13
`define BSK_SKIP_OPC_LO  10
`define BSK_SKIP_OPC     4'h7
// Opcode field of the call instruction
`define BSK_CALL_OPC_HI  13
`define BSK_CALL_OPC_LO  11
`define BSK_CALL_OPC     3'h4
// Operand fields
`define BSK_BIT_HI       9
`define BSK_BIT_LO       7
`define BSK_REG_HI       6
`define BSK_REG_LO       0
`define BSK_LIT_HI       10
`define BSK_LIT_LO       0
// Page bits taken from the page-select latch
`define BSK_PAGE_HI      4
`define BSK_PAGE_LO      3
// Phases per instruction cycle, one mclk each
`define BSK_Q_PHASES     3'h4
`define BSK_Q1           2'h0
`define BSK_Q2           2'h1
`define BSK_Q3           2'h2
`define BSK_Q4           2'h3
// Reset values
`define BSK_PC_RST       13'h0000
`define BSK_ADDR_RST     7'h00

`endif

// ### design/bsk_pkg.sv
// Types for the bit-test-skip and call execution block.
// Assumes bsk_map.svh is on the include path.
package bsk_pkg;

	// Operation held for the current instruction cycle
	typedef enum logic [1:0] {
		OP_OTHER = 2'b00,
		OP_SKIP  = 2'b01,
		OP_CALL  = 2'b10,
		OP_NOP   = 2'b11
	} bsk_op_t;

	typedef logic [1:0]  bsk_q_t;
	typedef logic [13:0] bsk_instr_t;
	typedef logic [12:0] bsk_pc_t;
	typedef logic [7:0]  bsk_data_t;
	typedef logic [6:0]  bsk_addr_t;

endpackage

// ### design/bsk_phase_if.sv
// Phase signals shared between the phase generator and the executer.
// Assumes both ends run on the same mclk.
`timescale 1ns/1ps
interface bsk_phase_if;
	import bsk_pkg::*;
	bsk_q_t q;          // Current phase, Q1..Q4 as 0..3
	logic   cyc_start;  // High during Q1

	modport gen (output q, output cyc_start);
	modport use_side (input q, input cyc_start);
endinterface

// ### design/bsk_phase_gen.sv
// Four-phase instruction cycle generator.
// Assumes one mclk per phase and a shared asynchronous reset.
`timescale 1ns/1ps
`include "bsk_map.svh"
module bsk_phase_gen (
	input  wire logic mclk,
	input  wire logic reset_n,
	bsk_phase_if.gen  ph
);
	import bsk_pkg::*;

	typedef struct packed {
		bsk_q_t q;
	} bsk_phase_st_t;

	bsk_phase_st_t st_reg;
	bsk_phase_st_t st_next;

	// Wraps naturally after Q4
	always_comb begin
		st_next   = st_reg;
		st_next.q = st_reg.q + 2'h1;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg.q <= `BSK_Q1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign ph.q         = st_reg.q;
	assign ph.cyc_start = (st_reg.q == `BSK_Q1);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	a_phase_order: assert property (ph.cyc_start |=> (ph.q == `BSK_Q2) ##1 (ph.q == `BSK_Q3) ##1 (ph.q == `BSK_Q4))
		else $error("phase sequence broken");
endmodule

// ### design/bsk_exec.sv
// Executes the bit-test-skip-if-set and call instructions.
// Other opcodes pass through untouched; the rest of the core runs them.
// Assumes the core presents the fetched word and its address from Q1,
// and returns register data one mclk after the read enable.
// Assumes the core applies stack_push and pc_load on the edge they stand at.
`timescale 1ns/1ps
`include "bsk_map.svh"
// Contract
// - Skip instruction with tested bit one discards the next fetched instruction.
// - Tested bit zero lets the next instruction run, no extra cycle.
// - A discarded instruction becomes a cycle with no read, process or write.
// - Skip instruction lasts one cycle, or two when skipping.
// - Call pushes the address of the next instruction onto the stack.
// - Call loads its eleven-bit literal into program counter bits 10:0.
module bsk_exec (
	input  wire logic               mclk,
	input  wire logic               reset_n,
	input  wire bsk_pkg::bsk_instr_t instr_word,
	input  wire bsk_pkg::bsk_pc_t    pc_value,
	input  wire bsk_pkg::bsk_data_t  pc_page_select_latch,
	input  wire bsk_pkg::bsk_data_t  reg_rd_data,
	output logic                    reg_rd_en,
	output bsk_pkg::bsk_addr_t      reg_rd_addr,
	output logic                    stack_push,
	output bsk_pkg::bsk_pc_t        stack_top_entry,
	output logic                    pc_load,
	output bsk_pkg::bsk_pc_t        pc_load_value,
	output logic                    exec_nop,
	output bsk_pkg::bsk_q_t         q_phase
);
	import bsk_pkg::*;

	// All state in one word; op says what this instruction cycle does
	typedef struct packed {
		bsk_op_t   op;
		bsk_addr_t addr;
		logic [2:0] bsel;
		logic [10:0] lit;
		logic [1:0] page;
		logic      skip;
		logic      rd_en;
		logic      push;
		bsk_pc_t   push_data;
		logic      load;
		bsk_pc_t   load_value;
	} bsk_exec_st_t;

	bsk_exec_st_t st_reg;
	bsk_exec_st_t st_next;

	// Phase bus shared with the generator
	bsk_phase_if ph ();

	// Q1..Q4 counter; one mclk per phase, no clock enable needed
	bsk_phase_gen u_phase (
		.mclk    (mclk),
		.reset_n (reset_n),
		.ph      (ph.gen)
	);

	// Decoded opcode flags
	logic is_skip;
	logic is_call;

	// Opcode decode of the fetched word
	// Only looked at in Q1, so a word changing mid-cycle does no harm
	assign is_skip = (instr_word[`BSK_SKIP_OPC_HI:`BSK_SKIP_OPC_LO] == `BSK_SKIP_OPC);
	assign is_call = (instr_word[`BSK_CALL_OPC_HI:`BSK_CALL_OPC_LO] == `BSK_CALL_OPC);

	// Next state, one step per phase
	// Strobes default low so each stands for a single phase; the data
	// fields hold until the next decode, which keeps the core's view steady
	always_comb begin
		st_next       = st_reg;
		st_next.rd_en = 1'b0;
		st_next.push  = 1'b0;
		st_next.load  = 1'b0;
		unique case (ph.q)
			`BSK_Q1: begin
				st_next.skip = 1'b0;
				// discarded word
				// A pending skip replaces the word with a silent cycle
				// second cycle added
				// Skip or call found here is dropped as well
				if (st_reg.skip) begin
					st_next.op = OP_NOP;
				end else if (is_skip) begin
					st_next.op    = OP_SKIP;
					st_next.addr  = instr_word[`BSK_REG_HI:`BSK_REG_LO];
					st_next.bsel  = instr_word[`BSK_BIT_HI:`BSK_BIT_LO];
					st_next.rd_en = 1'b1;
				end else if (is_call) begin
					st_next.op   = OP_CALL;
					st_next.lit  = instr_word[`BSK_LIT_HI:`BSK_LIT_LO];
					st_next.page = pc_page_select_latch[`BSK_PAGE_HI:`BSK_PAGE_LO];
					st_next.push      = 1'b1;
					st_next.push_data = pc_value + 13'h0001;
				end else begin
					st_next.op = OP_OTHER;
				end
			end
			`BSK_Q2: begin
				// Strobes from Q1 stand here; nothing to decide
			end
			`BSK_Q3: begin
				if (st_reg.op == OP_SKIP) begin
					st_next.skip = reg_rd_data[st_reg.bsel];
				end
				if (st_reg.op == OP_CALL) begin
					st_next.skip = 1'b1;
					st_next.load = 1'b1;
					st_next.load_value = {st_reg.page, st_reg.lit};
				end
			end
			`BSK_Q4: begin
				// Load strobe stands here; the flag waits for Q1
			end
		endcase
	end

	// Every field has a constant reset value
	// A reset in mid-call drops the call; no half push survives
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg.op         <= OP_OTHER;
			st_reg.addr       <= `BSK_ADDR_RST;
			st_reg.bsel       <= 3'h0;
			st_reg.lit        <= 11'h000;
			st_reg.page       <= 2'h0;
			st_reg.skip       <= 1'b0;
			st_reg.rd_en      <= 1'b0;
			st_reg.push       <= 1'b0;
			st_reg.push_data  <= `BSK_PC_RST;
			st_reg.load       <= 1'b0;
			st_reg.load_value <= `BSK_PC_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state flops, except exec_nop, decoded from op
	// q_phase lets the core line its own fetch up with Q1
	assign reg_rd_en       = st_reg.rd_en;
	assign reg_rd_addr     = st_reg.addr;
	assign stack_push      = st_reg.push;
	assign stack_top_entry = st_reg.push_data;
	assign pc_load         = st_reg.load;
	assign pc_load_value   = st_reg.load_value;
	assign exec_nop        = (st_reg.op == OP_NOP);
	assign q_phase         = ph.q;

	// Checks, all on mclk
	// Expected addresses, literal and page bits come from the sampled inputs, not the state fields,
	// so a broken capture path still trips them
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// Tested bit as the read returns it
	logic bit_now;
	assign bit_now = reg_rd_data[st_reg.bsel];

	// Skip decision, taken at the end of Q3
	a_skip_on_set: assert property ((ph.q == `BSK_Q3) && (st_reg.op == OP_SKIP) && bit_now |-> ##3 exec_nop)
		else $error("set bit did not discard next word");
	a_run_on_clear: assert property ((ph.q == `BSK_Q3) && (st_reg.op == OP_SKIP) && !bit_now |-> ##3 !exec_nop)
		else $error("clear bit wrongly skipped");
	a_skip_read: assert property (ph.cyc_start && is_skip && !st_reg.skip |=> reg_rd_en)
		else $error("skip did not read its register");
	a_other_quiet: assert property (ph.cyc_start && !st_reg.skip && !is_skip && !is_call
		|=> !reg_rd_en && !stack_push && !exec_nop)
		else $error("plain word disturbed");

	// Skip length; the silent cycle is a full four phases, because the
	// flag is only consumed at the next Q1
	a_skip_length: assert property ((ph.q == `BSK_Q4) && (st_reg.op == OP_SKIP) && st_reg.skip
		|-> ##2 exec_nop ##4 !exec_nop)
		else $error("skip did not take exactly two cycles");
	a_nop_four: assert property ($rose(exec_nop) |-> exec_nop[*4] ##1 !exec_nop)
		else $error("discarded cycle not four phases long");

	// Strobe placement; the core acts on each strobe once, so a second
	// phase of it would double a read, a push or a load
	a_rd_strobe: assert property (reg_rd_en |-> (ph.q == `BSK_Q2)
		&& (reg_rd_addr == $past(instr_word[`BSK_REG_HI:`BSK_REG_LO])) ##1 !reg_rd_en)
		else $error("register read strobe misplaced");
	a_push_strobe: assert property (stack_push |-> (ph.q == `BSK_Q2) ##1 !stack_push)
		else $error("stack push strobe misplaced");
	a_load_strobe: assert property (pc_load |-> (ph.q == `BSK_Q4) ##1 !pc_load)
		else $error("program counter load misplaced");

	// Call: return address, literal and page bits, all traced back
	// to the word, program counter and latch seen at the Q1 edge
	a_call_push: assert property (ph.cyc_start && is_call && !st_reg.skip
		|=> stack_push && (stack_top_entry == $past(pc_value) + 13'h0001))
		else $error("call pushed wrong return address");
	a_call_literal: assert property ((ph.q == `BSK_Q2) && (st_reg.op == OP_CALL)
		|-> ##2 pc_load && (pc_load_value[10:0] == $past(instr_word[`BSK_LIT_HI:`BSK_LIT_LO], 3)))
		else $error("call literal not loaded");
	a_call_page: assert property (pc_load
		|-> (pc_load_value[12:11] == $past(pc_page_select_latch[`BSK_PAGE_HI:`BSK_PAGE_LO], 3)))
		else $error("page bits wrong on call");
	a_call_two_cyc: assert property ((ph.q == `BSK_Q2) && (st_reg.op == OP_CALL) |-> ##4 exec_nop)
		else $error("call second cycle not silent");

	// Discarded cycle: no strobe and no data output moves
	a_nop_silent: assert property (exec_nop |-> !reg_rd_en && !stack_push && !pc_load)
		else $error("activity in a discarded cycle");
	a_nop_holds: assert property (exec_nop
		|-> $stable(reg_rd_addr) && $stable(stack_top_entry) && $stable(pc_load_value))
		else $error("output changed in a discarded cycle");

	// Main scenarios
	c_skip_taken: cover property ((ph.q == `BSK_Q3) && (st_reg.op == OP_SKIP) && bit_now);
	c_skip_not_taken: cover property ((ph.q == `BSK_Q3) && (st_reg.op == OP_SKIP) && !bit_now);
	c_call_done: cover property (pc_load ##2 exec_nop);
	c_call_discarded: cover property (ph.cyc_start && is_call && st_reg.skip);
	c_skip_discarded: cover property (ph.cyc_start && is_skip && st_reg.skip);
endmodule

// ### bench/bsk_core_model.sv
// Far-side model: read port of the core's data register file.
// Assumes data is wanted one mclk after the read enable.
`timescale 1ns/1ps
module bsk_core_model (
	input  wire logic               mclk,
	input  wire logic               reg_rd_en,
	input  wire bsk_pkg::bsk_addr_t reg_rd_addr,
	output bsk_pkg::bsk_data_t      reg_rd_data
);
	// Contents are address xor 5a; idle data toggles so stale reads show
	// One process owns the data: it starts at zero, then follows mclk
	initial begin
		reg_rd_data = 8'h00;
		forever begin
			@(posedge mclk);
			reg_rd_data <= reg_rd_en ? {1'h0, reg_rd_addr} ^ 8'h5a : ~reg_rd_data;
		end
	end
endmodule

// ### bench/testbench.sv
// Self-checking bench for the skip and call executer.
// Assumes the core model answers register reads.
`timescale 1ns/1ps
module testbench;
	import bsk_pkg::*;
	// Row flags are {read, call, discard next}
	typedef struct {bsk_instr_t w; bsk_data_t lat; logic [2:0] fl; bsk_pc_t val;} bsk_row_t;
	logic       mclk, reset_n, reg_rd_en, stack_push, pc_load, exec_nop;
	bsk_instr_t instr_word;
	bsk_pc_t    pc_value, stack_top_entry, pc_load_value;
	bsk_data_t  pc_page_select_latch, reg_rd_data;
	bsk_addr_t  reg_rd_addr;
	bsk_q_t     q_phase;
	logic [2:0] n_rd, n_push, n_ld, n_nop;
	int         err_count, cmp_count;
	bsk_row_t   rows [8] = '{
		'{14'h1c80, 8'h00, 3'h5, 13'h0000}, '{14'h1c00, 8'h00, 3'h4, 13'h0000},
		'{14'h1f80, 8'h00, 3'h4, 13'h0000}, '{14'h1c7f, 8'h00, 3'h5, 13'h0000},
		'{14'h1f7f, 8'h00, 3'h4, 13'h0000}, '{14'h27ff, 8'h18, 3'h3, 13'h1fff},
		'{14'h2555, 8'h08, 3'h3, 13'h0d55}, '{14'h1000, 8'h00, 3'h0, 13'h0000}};

	bsk_exec dut (.mclk, .reset_n, .instr_word, .pc_value, .pc_page_select_latch, .reg_rd_data,
		.reg_rd_en, .reg_rd_addr, .stack_push, .stack_top_entry, .pc_load, .pc_load_value,
		.exec_nop, .q_phase);
	bsk_core_model core (.mclk, .reg_rd_en, .reg_rd_addr, .reg_rd_data);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One instruction cycle from a Q1 falling edge; strobes tallied per phase
	task automatic cyc(input bsk_instr_t w, input bsk_pc_t pc, input bsk_data_t lat);
		instr_word = w;
		pc_value = pc;
		pc_page_select_latch = lat;
		{n_rd, n_push, n_ld, n_nop} = 12'h000;
		repeat (4) begin
			@(negedge mclk);
			n_rd += 3'(reg_rd_en);
			n_push += 3'(stack_push);
			n_ld += 3'(pc_load);
			n_nop += 3'(exec_nop);
		end
	endtask

	task automatic final_report;
		$display("compares=%0d mismatches=%0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		mclk = 1'h0;
		forever #12.5 mclk = ~mclk;
	end

	// Whole run is about 123 mclks; 2000 leaves ample margin
	initial begin
		#50000;
		err_count++;
		final_report;
	end

	initial begin
		{reset_n, instr_word, pc_value, pc_page_select_latch} = 36'h0;
		err_count = 0;
		cmp_count = 0;
		repeat (8) @(negedge mclk);
		reset_n = 1'h1;
		// Each row: instruction, then a probe call, then a filler cycle
		foreach (rows[i]) begin
			cyc(rows[i].w, 13'h0100 + 13'(i), rows[i].lat);
			check(32'(n_rd), 32'(rows[i].fl[2]));
			check(32'({n_push, n_ld}), 32'({3'(rows[i].fl[1]), 3'(rows[i].fl[1])}));
			if (rows[i].fl[2])
				check(32'(reg_rd_addr), 32'(rows[i].w[6:0]));
			if (rows[i].fl[1])
				check(32'({stack_top_entry, pc_load_value}), 32'({13'h0101 + 13'(i), rows[i].val}));
			check(32'(q_phase), 32'h0);
			cyc(14'h2123, 13'h0400, 8'h00);
			check(32'({n_rd, n_push, n_ld}), rows[i].fl[0] ? 32'h000 : 32'h009);
			check(32'(n_nop), rows[i].fl[0] ? 32'h4 : 32'h0);
			cyc(14'h0000, 13'h0401, 8'h00);
			check(32'(n_nop), rows[i].fl[0] ? 32'h0 : 32'h4);
			$display("row %0d done", i);
		end
		// A skip landing in a discarded slot must not read
		cyc(14'h1c80, 13'h0200, 8'h00);
		cyc(14'h1c80, 13'h0201, 8'h00);
		check(32'(n_rd), 32'h0);
		cyc(14'h1c00, 13'h0202, 8'h00);
		check(32'(n_rd), 32'h1);
		$display("discarded skip done");
		// Reset in mid-call clears all outputs, then a call runs again
		instr_word = 14'h2555;
		repeat (2) @(negedge mclk);
		reset_n = 1'h0;
		@(negedge mclk);
		check({reg_rd_en, stack_push, pc_load, exec_nop, q_phase, stack_top_entry, pc_load_value}, 32'h0);
		reset_n = 1'h1;
		cyc(14'h2000, 13'h07ff, 8'h18);
		check(32'({stack_top_entry, pc_load_value}), 32'({13'h0800, 13'h1800}));
		$display("mid-run reset done");
		final_report;
	end
endmodule
